// ---- common/swc_pkg.sv ----
package swc_pkg;

    // Sleep state encodings, one-hot
    localparam int STATE_W = 4;

    typedef enum logic [STATE_W-1:0] {
        SWC_RUN = 4'h1,
        SWC_SLEEP_WI = 4'h2,
        SWC_SLEEP_WE = 4'h4,
        SWC_HOLD = 4'h8
    } swc_state_e;

    // Sleep cause codes shown on the cause output
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_WAIT_INT = 2'h1;
    localparam logic [1:0] CAUSE_EXIT = 2'h2;
    localparam logic [1:0] CAUSE_WAIT_EVT = 2'h3;

    // Reset value and reset synchronizer depth
    localparam logic EVENT_RESET = 1'b0;
    localparam int SYNC_STAGES = 2;

endpackage

// ---- rtl/swc_rise_detect.sv ----
`timescale 1ns/1ps
// Flags a new rise on any bit of a pending vector
module swc_rise_detect #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Vector in, pulse out
    input wire logic [WIDTH-1:0] level_in,
    output logic any_rise
);

    typedef struct packed {
        logic [WIDTH-1:0] prev;
    } swc_rd_s;

    swc_rd_s r_q;
    swc_rd_s r_d;

    always_comb
    begin
        r_d = r_q;
        r_d.prev = level_in;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign any_rise = |(level_in & ~r_q.prev);

endmodule

// ---- rtl/swc_sleep_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - With sleep-after-handler set, handler return goes straight to sleep, no thread code.
// - Sleep from wait-for-interrupt or handler exit wakes on an entry-worthy exception or a masked wake, not on events.
// - Priority mask set, fault mask clear: enabled higher-priority interrupt still wakes core from wait-for-interrupt or handler-exit sleep.
// - That wake resumes thread code; handler entry held until priority mask clears.
// - Wait-for-event sleep wakes on an exception able to cause exception entry.
// - Event-on-pending set: any new pending interrupt wakes wait-for-event sleep.
// - Wait-for-interrupt halts execution and sleeps at once, except in the hold state, where it is ignored.
// - Wait-for-event: event flag 0 sleeps; flag 1 is cleared and execution continues; in the hold state it is ignored.
// - Deep-sleep select chooses sleep depth whenever any sleep mechanism triggers.
module swc_sleep_ctrl #(
    parameter int NUM_IRQ = 8
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST_B,
    // System control register bits
    input wire logic SLEEP_AFTER_HANDLER_BIT,
    input wire logic EVENT_ON_PENDING_BIT,
    input wire logic DEEP_SLEEP_SELECT_BIT,
    // Exception mask bits
    input wire logic PRIORITY_MASK_BIT,
    input wire logic FAULT_MASK_BIT,
    // Pipeline requests, one-cycle pulses
    input wire logic WAIT_INTERRUPT_INSTR,
    input wire logic WAIT_EVENT_INSTR,
    input wire logic HANDLER_RETURN,
    input wire logic SEND_EVENT,
    // Exception logic status
    input wire logic EXC_ENTRY_READY,
    input wire logic IRQ_ABOVE_PRIORITY,
    input wire logic [NUM_IRQ-1:0] IRQ_PENDING,
    // Core control
    output logic CORE_HALT,
    output logic SLEEP_ACTIVE,
    output logic DEEP_SLEEP,
    output logic WAKEUP,
    output logic EXC_ENTRY_HOLD,
    output logic EVENT_FLAG,
    output logic [1:0] SLEEP_CAUSE
);

    typedef struct packed {
        swc_pkg::swc_state_e state;
        logic event_flag;
        logic deep;
        logic wake;
        logic [1:0] cause;
    } swc_s;

    swc_s s_q;
    swc_s s_d;
    logic [swc_pkg::SYNC_STAGES-1:0] rst_sync_q;
    logic rst_n;
    logic pend_rise;
    logic entry_wake;
    logic masked_wake;
    logic any_event;

    // Reset release through two stages
    always_ff @(posedge CLOCK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rst_sync_q <= '0;
        end
        else
        begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1];

    // Pending vector comes from same-clock exception logic
    swc_rise_detect #(
        .WIDTH(NUM_IRQ)
    ) i_swc_rise_detect (
        .clk(CLOCK),
        .rst_n(rst_n),
        .level_in(IRQ_PENDING),
        .any_rise(pend_rise)
    );

    // Masked wake only with priority mask set and fault mask clear
    assign masked_wake = PRIORITY_MASK_BIT && !FAULT_MASK_BIT && IRQ_ABOVE_PRIORITY;
    assign entry_wake = EXC_ENTRY_READY;
    assign any_event = SEND_EVENT || (EVENT_ON_PENDING_BIT && pend_rise);

    always_comb
    begin
        s_d = s_q;
        s_d.wake = 1'b0;
        case (s_q.state)
            swc_pkg::SWC_RUN:
            begin
                // Event arriving with a wait-for-event still counts: no sleep, clear wins
                if (WAIT_INTERRUPT_INSTR)
                begin
                    s_d.state = swc_pkg::SWC_SLEEP_WI;
                    s_d.cause = swc_pkg::CAUSE_WAIT_INT;
                    s_d.deep = DEEP_SLEEP_SELECT_BIT;
                    s_d.event_flag = s_q.event_flag || any_event;
                end
                else if (HANDLER_RETURN && SLEEP_AFTER_HANDLER_BIT)
                begin
                    s_d.state = swc_pkg::SWC_SLEEP_WI;
                    s_d.cause = swc_pkg::CAUSE_EXIT;
                    s_d.deep = DEEP_SLEEP_SELECT_BIT;
                    s_d.event_flag = s_q.event_flag || any_event;
                end
                else if (WAIT_EVENT_INSTR)
                begin
                    if (s_q.event_flag || any_event)
                    begin
                        s_d.event_flag = 1'b0;
                    end
                    else
                    begin
                        s_d.state = swc_pkg::SWC_SLEEP_WE;
                        s_d.cause = swc_pkg::CAUSE_WAIT_EVT;
                        s_d.deep = DEEP_SLEEP_SELECT_BIT;
                    end
                end
                else if (any_event)
                begin
                    s_d.event_flag = 1'b1;
                end
            end
            swc_pkg::SWC_SLEEP_WI:
            begin
                // Other events are remembered for a later wait-for-event
                if (any_event)
                begin
                    s_d.event_flag = 1'b1;
                end
                if (entry_wake)
                begin
                    s_d.state = swc_pkg::SWC_RUN;
                    s_d.wake = 1'b1;
                    s_d.cause = swc_pkg::CAUSE_NONE;
                    s_d.deep = 1'b0;
                end
                else if (masked_wake)
                begin
                    s_d.state = swc_pkg::SWC_HOLD;
                    s_d.wake = 1'b1;
                    s_d.cause = swc_pkg::CAUSE_NONE;
                    s_d.deep = 1'b0;
                end
            end
            swc_pkg::SWC_SLEEP_WE:
            begin
                // Waking event is consumed, flag stays clear
                if (entry_wake || any_event)
                begin
                    s_d.state = swc_pkg::SWC_RUN;
                    s_d.wake = 1'b1;
                    s_d.cause = swc_pkg::CAUSE_NONE;
                    s_d.deep = 1'b0;
                end
            end
            swc_pkg::SWC_HOLD:
            begin
                // Thread code runs; handler entry waits for the mask to drop
                if (any_event)
                begin
                    s_d.event_flag = 1'b1;
                end
                if (!PRIORITY_MASK_BIT)
                begin
                    s_d.state = swc_pkg::SWC_RUN;
                end
            end
            default:
            begin
                s_d.state = swc_pkg::SWC_RUN;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q.state <= swc_pkg::SWC_RUN;
            s_q.event_flag <= swc_pkg::EVENT_RESET;
            s_q.deep <= 1'b0;
            s_q.wake <= 1'b0;
            s_q.cause <= swc_pkg::CAUSE_NONE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // All outputs register decodes of next state s_d, on the same edge as the state
    always_ff @(posedge CLOCK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            CORE_HALT <= 1'b0;
            SLEEP_ACTIVE <= 1'b0;
            DEEP_SLEEP <= 1'b0;
            WAKEUP <= 1'b0;
            EXC_ENTRY_HOLD <= 1'b0;
            EVENT_FLAG <= swc_pkg::EVENT_RESET;
            SLEEP_CAUSE <= swc_pkg::CAUSE_NONE;
        end
        else
        begin
            CORE_HALT <= (s_d.state == swc_pkg::SWC_SLEEP_WI)
                || (s_d.state == swc_pkg::SWC_SLEEP_WE);
            SLEEP_ACTIVE <= (s_d.state == swc_pkg::SWC_SLEEP_WI)
                || (s_d.state == swc_pkg::SWC_SLEEP_WE);
            DEEP_SLEEP <= s_d.deep;
            WAKEUP <= s_d.wake;
            EXC_ENTRY_HOLD <= (s_d.state == swc_pkg::SWC_HOLD);
            EVENT_FLAG <= s_d.event_flag;
            SLEEP_CAUSE <= s_d.cause;
        end
    end

endmodule

// ---- verification/swc_sleep_props.sv ----
`timescale 1ns/1ps
module swc_sleep_props (
    // Watched inputs
    input wire logic CLOCK,
    RST_B,
    SLEEP_AFTER_HANDLER_BIT,
    EVENT_ON_PENDING_BIT,
    DEEP_SLEEP_SELECT_BIT,
    PRIORITY_MASK_BIT,
    FAULT_MASK_BIT,
    WAIT_INTERRUPT_INSTR,
    WAIT_EVENT_INSTR,
    HANDLER_RETURN,
    SEND_EVENT,
    EXC_ENTRY_READY,
    IRQ_ABOVE_PRIORITY,
    // Watched outputs
    CORE_HALT,
    DEEP_SLEEP,
    WAKEUP,
    EXC_ENTRY_HOLD,
    EVENT_FLAG,
    input wire logic [1:0] SLEEP_CAUSE
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_B);
    // Outputs follow state on the same edge; two-edge answers leave slack
    wire run = !CORE_HALT && !EXC_ENTRY_HOLD;
    a_wait_int_sleeps: assert property (
        WAIT_INTERRUPT_INSTR && run |-> ##2 CORE_HALT && SLEEP_CAUSE == 2'h1)
        else $error("wait-interrupt no sleep");
    a_exit_sleeps: assert property (
        HANDLER_RETURN && SLEEP_AFTER_HANDLER_BIT && run && !WAIT_INTERRUPT_INSTR
        |-> ##2 CORE_HALT && SLEEP_CAUSE == 2'h2)
        else $error("exit no sleep");
    a_deep_select: assert property (
        $rose(CORE_HALT) |-> DEEP_SLEEP == $past(DEEP_SLEEP_SELECT_BIT))
        else $error("bad depth");
    a_entry_wakes: assert property (
        CORE_HALT && EXC_ENTRY_READY |-> ##[1:2] WAKEUP)
        else $error("no wake");
    a_masked_wake: assert property (
        CORE_HALT && SLEEP_CAUSE != 2'h3 && PRIORITY_MASK_BIT && !FAULT_MASK_BIT
        && IRQ_ABOVE_PRIORITY && !EXC_ENTRY_READY |-> ##[1:2] !CORE_HALT && EXC_ENTRY_HOLD)
        else $error("no masked wake");
    a_hold_mask: assert property (
        EXC_ENTRY_HOLD && PRIORITY_MASK_BIT && $past(PRIORITY_MASK_BIT) |=> EXC_ENTRY_HOLD)
        else $error("hold lost");
    a_hold_release: assert property (
        EXC_ENTRY_HOLD && !PRIORITY_MASK_BIT |=> !EXC_ENTRY_HOLD)
        else $error("hold not released");
    a_wait_evt_skip: assert property (
        WAIT_EVENT_INSTR && EVENT_FLAG && run && !SEND_EVENT && !EVENT_ON_PENDING_BIT
        |-> ##2 !CORE_HALT && !EVENT_FLAG)
        else $error("wait-event slept");
    a_sev_flag: assert property (
        SEND_EVENT && run && !WAIT_EVENT_INSTR |-> ##2 EVENT_FLAG)
        else $error("no event flag");
endmodule
bind swc_sleep_ctrl swc_sleep_props i_swc_sleep_props (.*);

// ---- verification/swc_exc_model.sv ----
`timescale 1ns/1ps
// Exception logic stand-in; slow adds a cycle of lag
module swc_exc_model (
    // Clock and stimulus
    input wire logic clk,
    input wire logic slow,
    input wire logic [9:0] req,
    // Status toward the sequencer
    output logic entry_ready,
    output logic irq_above,
    output logic [7:0] irq_pending
);
    logic [9:0] a_q, b_q;
    always_ff @(posedge clk)
    begin
        a_q <= req;
        b_q <= a_q;
    end
    assign {entry_ready, irq_above, irq_pending} = slow ? b_q : a_q;
endmodule

// ---- verification/swc_sleep_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module swc_sleep_ctrl_tb_top;
    logic clk = 0, rst_b = 0, sah = 0, eop = 0, dsel = 0, pm = 0, fm = 0, slow = 0, h = 0;
    logic ready, above, halt, act, deep, wake, hold, flag;
    logic [1:0] cause;
    logic [3:0] ins = 4'h0;
    logic [7:0] pend, rnd;
    logic [9:0] req = 10'h000;
    logic [3:0] q[$];
    int bad_count = 0, num_checks = 0;
    initial forever #5 clk = ~clk;
    swc_sleep_ctrl i_swc_sleep_ctrl (.CLOCK(clk), .RST_B(rst_b),
        .SLEEP_AFTER_HANDLER_BIT(sah), .EVENT_ON_PENDING_BIT(eop), .DEEP_SLEEP_SELECT_BIT(dsel),
        .PRIORITY_MASK_BIT(pm), .FAULT_MASK_BIT(fm), .WAIT_INTERRUPT_INSTR(ins[0]),
        .WAIT_EVENT_INSTR(ins[1]), .HANDLER_RETURN(ins[2]), .SEND_EVENT(ins[3]),
        .EXC_ENTRY_READY(ready), .IRQ_ABOVE_PRIORITY(above), .IRQ_PENDING(pend),
        .CORE_HALT(halt), .SLEEP_ACTIVE(act), .DEEP_SLEEP(deep), .WAKEUP(wake),
        .EXC_ENTRY_HOLD(hold), .EVENT_FLAG(flag), .SLEEP_CAUSE(cause));
    swc_exc_model i_swc_exc_model (.clk(clk), .slow(slow), .req(req),
        .entry_ready(ready), .irq_above(above), .irq_pending(pend));
    task chk(input string name, input logic [3:0] s, input logic [3:0] e);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %s exp %h got %h", name, e, s);
        end
    endtask
    // Unexpected result meets an unknown note, which no output can match
    function logic [3:0] nx();
        return q.size() ? q.pop_front() : 4'hX;
    endfunction
    task w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task sl(input int i, input logic [3:0] e);
        if (e)
            q.push_back(e);
        ins[i] = 1'b1;
        w(1);
        ins[i] = 1'b0;
        w(4);
    endtask
    task wk(input logic [9:0] r, input logic [3:0] e);
        q.push_back(e);
        req = r;
        w(6);
        req = 10'h000;
        w(3);
    endtask
    task final_report;
        // Notes never matched by a result count together as one miss
        if (q.size() != 0)
            bad_count++;
        $display("checks %0d bad %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    always @(negedge clk)
    begin
        if (halt && !h)
            chk("sleep", {act, deep, cause}, nx());
        if (wake)
            chk("wake", {deep, act, hold, flag}, nx());
        h = halt;
    end
    initial
    begin
        #20us;
        bad_count++;
        final_report;
    end
    initial
    begin
        void'($urandom(15));
        w(2);
        rst_b = 1'b1;
        w(4);
        for (int d = 0; d < 2; d++)
        begin
            dsel = d[0];
            sl(0, {1'b1, dsel, 2'h1});
            wk(10'h200, 4'h0);
        end
        $display("test wait interrupt done");
        sah = 1'b1;
        slow = 1'b1;
        sl(2, {1'b1, dsel, 2'h2});
        wk(10'h200, 4'h0);
        sah = 1'b0;
        slow = 1'b0;
        sl(2, 4'h0);
        $display("test exit done");
        pm = 1'b1;
        sl(0, {1'b1, dsel, 2'h1});
        wk(10'h100, 4'h2);
        pm = 1'b0;
        w(3);
        $display("test masked done");
        eop = 1'b1;
        rnd = 8'h01 << ($urandom % 8);
        sl(1, {1'b1, dsel, 2'h3});
        wk({2'b00, rnd}, 4'h0);
        eop = 1'b0;
        sl(1, {1'b1, dsel, 2'h3});
        req = {2'b00, rnd};
        w(4);
        wk({2'b10, rnd}, 4'h0);
        sl(1, {1'b1, dsel, 2'h3});
        q.push_back(4'h0);
        sl(3, 4'h0);
        sl(3, 4'h0);
        sl(1, 4'h0);
        sl(0, {1'b1, dsel, 2'h1});
        wk(10'h200, 4'h0);
        $display("test event done");
        final_report;
    end
endmodule
